// ==== plug_detect_pkg.sv ====
// shared constants and carrier types for the plug-detect block
package plug_detect_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] irq_flags_addr          = 8'h00;
  localparam logic [7:0] plug_level_addr         = 8'h01;
  localparam logic [7:0] irq_mask_addr           = 8'h04;
  localparam logic [7:0] plug_detect_config_addr = 8'h25;
  localparam logic [7:0] irq_mask_reset          = 8'h00;
  localparam logic [7:0] plug_detect_config_reset = 8'h00;
  localparam logic [7:0] unmapped_read_value     = 8'h00;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int plug_change_bit    = 1;
  localparam int plug_detect_on_bit = 7;
  localparam int low_power_pullup_bit = 5;
  localparam int level_lsb          = 6;
  localparam logic [7:0] irq_mask_writable = 8'he2;
  localparam logic [7:0] config_writable   = 8'ha3;

  // -----------------------------------------------------------------
  // sense level codes
  // -----------------------------------------------------------------
  localparam logic [1:0] level_low     = 2'h0;
  localparam logic [1:0] level_mid     = 2'h1;
  localparam logic [1:0] level_invalid = 2'h2;
  localparam logic [1:0] level_high    = 2'h3;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int clk_hz        = 10_000_000;
  localparam int tick_us       = 1000;
  localparam int tick_cycles   = clk_hz / 1_000_000 * tick_us;
  localparam int settle_ms_0   = 25;
  localparam int settle_ms_1   = 50;
  localparam int settle_ms_2   = 100;
  localparam int settle_ms_3   = 200;

  typedef enum logic [1:0] {
    pull_off    = 2'h0,
    pull_strong = 2'h1,
    pull_weak   = 2'h2
  } pullup_sel_t;

  typedef struct packed {
    logic        access;
    logic        write;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic        plug_detect_on;
    logic        low_power_pullup;
    logic [1:0]  settle_time_sel;
  } config_t;

endpackage

// ==== settle_filter.sv ====
// debounce filter for the two-bit sense level
`timescale 1ns/100ps
module settle_filter
  import plug_detect_pkg::*;
#(
  parameter int tick_div = tick_cycles
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       enable,
  input  wire logic [1:0] settle_time_sel,
  // level in and out
  input  wire logic [1:0] raw_level,
  output logic [1:0]      stable_level,
  output logic            change_pulse
);

  // -----------------------------------------------------------------
  // millisecond tick
  // -----------------------------------------------------------------
  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_cnt_next;
  logic        tick;
  logic [7:0]  ms_cnt_reg;
  logic [7:0]  ms_cnt_next;
  logic [1:0]  cand_reg;
  logic [1:0]  cand_next;
  logic [1:0]  stable_reg;
  logic [1:0]  stable_next;
  logic        pulse_reg;
  logic        pulse_next;

  function automatic logic [7:0] settle_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0: settle_ms = 8'(settle_ms_0);
      2'h1: settle_ms = 8'(settle_ms_1);
      2'h2: settle_ms = 8'(settle_ms_2);
      2'h3: settle_ms = 8'(settle_ms_3);
    endcase
  endfunction

  assign tick = (tick_cnt_reg == 16'(tick_div - 1));

  always_comb begin
    tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    cand_next     = cand_reg;
    ms_cnt_next   = ms_cnt_reg;
    stable_next   = stable_reg;
    pulse_next    = 1'b0;
    if (!enable) begin
      cand_next   = raw_level;
      ms_cnt_next = 8'h00;
      stable_next = raw_level;
    end else if (raw_level != cand_reg) begin
      // any fresh change restarts the timer
      cand_next   = raw_level;                                  // [R19]
      ms_cnt_next = 8'h00;
    end else if (cand_reg != stable_reg && tick) begin
      if (ms_cnt_reg + 8'h01 >= settle_ms(settle_time_sel)) begin // [R9]
        stable_next = cand_reg;
        pulse_next  = 1'b1;                                     // [R8]
        ms_cnt_next = 8'h00;
      end else begin
        ms_cnt_next = ms_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 16'h0000;
      ms_cnt_reg   <= 8'h00;
      cand_reg     <= level_high;
      stable_reg   <= level_high;
      pulse_reg    <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      ms_cnt_reg   <= ms_cnt_next;
      cand_reg     <= cand_next;
      stable_reg   <= stable_next;
      pulse_reg    <= pulse_next;
    end
  end

  assign stable_level = stable_reg;
  assign change_pulse = pulse_reg;

endmodule

// ==== plug_detect_irq.sv ====
// plug detection with debounced change flag and open-drain interrupt
`timescale 1ns/100ps

// Notes on behaviour
// [R1] aux select 0 gives pin to plug detect, 1 to DC measurement.
// [R2] host setting aux select must zero right mix and enable both ADCs.
// [R3] host keeps aux select 0 for plug detection to work.
// [R4] sleep enables pull-ups only; normal mode also enables the comparator.
// [R5] detect enable applies pull-ups on the sense pin.
// [R6] sense level field reports pin state only while detection enabled.
// [R7] levels 00 low, 01 mid, 11 high; 10 never reported.
// [R8] change flag set only after a debounced level change.
// [R9] settle select 00/01/10/11 gives 25/50/100/200 ms.
// [R10] interrupt output is open-drain, active low.
// [R11] interrupt stays low until status register read.
// [R12] flag raises interrupt only when same-position mask bit is set.
// [R13] level register read-only, level in two top bits.
// [R14] low-power pull-up bit 0 selects strong pull-up.
// [R15] low-power bit 1 in sleep or bias off selects weak current source.
// [R16] any preamp gain bit forces strong pull-up.
// [R17] host clears low-power bit while waiting, sets it once type known.
// [R18] plug insertion or removal pulls interrupt low when enabled.
// [R19] debounce timer restarts on any new raw change.
// [R20] status read clears flag unless a new change lands same cycle.
module plug_detect_irq
  import plug_detect_pkg::*;
#(
  parameter int tick_div = tick_cycles
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // register port from the serial interface
  input  wire logic       reg_access,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // other device state
  input  wire logic       power_down_n,
  input  wire logic       mic_bias_on,
  input  wire logic       aux_measure_sel,
  input  wire logic [1:0] left_preamp_gain,
  input  wire logic [1:0] right_preamp_gain,
  // window comparator result from the sense pin
  input  wire logic [1:0] sense_pin_cmp,
  // analog controls
  output logic            pullup_strong_en,
  output logic            pullup_weak_en,
  output logic            comparator_en,
  output logic            aux_path_en,
  // open-drain interrupt pin
  input  wire logic       irq_n_in,
  output logic            irq_n_out,
  output logic            irq_n_oe
);

  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // -----------------------------------------------------------------
  // comparator input synchroniser
  // -----------------------------------------------------------------
  logic [1:0] cmp_s1_reg;
  logic [1:0] cmp_s2_reg;
  logic [1:0] cmp_s3_reg;
  logic [1:0] cmp_level_reg;
  logic [1:0] cmp_level_next;

  always_comb begin
    cmp_level_next = cmp_level_reg;
    if (cmp_s2_reg == cmp_s3_reg) begin
      cmp_level_next = cmp_s3_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_reg    <= level_high;
      cmp_s2_reg    <= level_high;
      cmp_s3_reg    <= level_high;
      cmp_level_reg <= level_high;
    end else begin
      cmp_s1_reg    <= sense_pin_cmp;
      cmp_s2_reg    <= cmp_s1_reg;
      cmp_s3_reg    <= cmp_s2_reg;
      cmp_level_reg <= cmp_level_next;
    end
  end

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  reg_req_t   req;
  config_t    cfg;
  logic [7:0] irq_mask_reg;
  logic [7:0] irq_mask_next;
  logic [7:0] config_reg;
  logic [7:0] config_next;

  assign req = '{access: reg_access, write: reg_write, addr: reg_addr, wdata: reg_wdata};
  assign cfg = '{plug_detect_on:   config_reg[plug_detect_on_bit],
                 low_power_pullup: config_reg[low_power_pullup_bit],
                 settle_time_sel:  config_reg[1:0]};

  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    hit = r.access && (r.addr == a);
  endfunction

  always_comb begin
    irq_mask_next = irq_mask_reg;
    config_next   = config_reg;
    if (hit(req, irq_mask_addr) && req.write) begin
      irq_mask_next = req.wdata & irq_mask_writable;
    end
    if (hit(req, plug_detect_config_addr) && req.write) begin
      config_next = req.wdata & config_writable;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= irq_mask_reset;
      config_reg   <= plug_detect_config_reset;
    end else begin
      irq_mask_reg <= irq_mask_next;
      config_reg   <= config_next;
    end
  end

  // -----------------------------------------------------------------
  // pin routing and pull-up choice
  // -----------------------------------------------------------------
  logic        detect_active;
  logic        gain_forces_strong;
  pullup_sel_t pull_sel;

  assign detect_active      = cfg.plug_detect_on && !aux_measure_sel;    // [R1]
  assign gain_forces_strong = |{left_preamp_gain, right_preamp_gain};    // [R16]

  always_comb begin
    pull_sel = pull_off;
    if (detect_active) begin
      pull_sel = pull_strong;                                            // [R5] [R14]
      if (cfg.low_power_pullup && !gain_forces_strong &&
          (!power_down_n || !mic_bias_on)) begin
        pull_sel = pull_weak;                                            // [R15]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_strong_en <= 1'b0;
      pullup_weak_en   <= 1'b0;
      comparator_en    <= 1'b0;
      aux_path_en      <= 1'b0;
    end else begin
      pullup_strong_en <= (pull_sel == pull_strong);
      pullup_weak_en   <= (pull_sel == pull_weak);
      comparator_en    <= detect_active && power_down_n;                 // [R4]
      aux_path_en      <= aux_measure_sel;                               // [R1]
    end
  end

  // -----------------------------------------------------------------
  // level decode and debounce
  // -----------------------------------------------------------------
  logic [1:0] raw_level;
  logic [1:0] stable_level;
  logic       change_pulse;

  // weak source cannot tell mic from ground, so headset reads low
  always_comb begin
    raw_level = cmp_level_reg;
    if (raw_level == level_invalid) begin
      raw_level = level_low;                                             // [R7]
    end
    if (pull_sel == pull_weak && raw_level == level_mid) begin
      raw_level = level_low;                                             // [R15]
    end
  end

  settle_filter #(
    .tick_div (tick_div)
  ) u_settle (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .enable          (detect_active),
    .settle_time_sel (cfg.settle_time_sel),
    .raw_level       (raw_level),
    .stable_level    (stable_level),
    .change_pulse    (change_pulse)
  );

  // -----------------------------------------------------------------
  // status flag and interrupt
  // -----------------------------------------------------------------
  logic       flag_reg;
  logic       flag_next;
  logic       status_read;
  logic [7:0] flags_word;
  logic       irq_reg;
  logic       irq_next;

  assign status_read = hit(req, irq_flags_addr) && !req.write;
  assign flags_word  = 8'(flag_reg) << plug_change_bit;

  always_comb begin
    flag_next = flag_reg;
    if (status_read) begin
      flag_next = 1'b0;                                                  // [R20]
    end
    if (change_pulse) begin
      flag_next = 1'b1;                                                  // [R8] [R20]
    end
    // once low the line holds until the status read
    irq_next = irq_reg;
    if (status_read) begin
      irq_next = 1'b0;                                                   // [R11]
    end
    if (|(flags_word & irq_mask_reg) && !status_read) begin
      irq_next = 1'b1;                                                   // [R12] [R18]
    end
    if (change_pulse && irq_mask_reg[plug_change_bit]) begin
      irq_next = 1'b1;                                                   // [R18]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      irq_reg  <= irq_next;
    end
  end

  // open drain: only ever drive low
  assign irq_n_out = 1'b0;                                               // [R10]
  assign irq_n_oe  = irq_reg;                                            // [R10]

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = unmapped_read_value;
    if (req.access && !req.write) begin
      unique case (req.addr)
        irq_flags_addr:  rdata_next = flags_word;
        plug_level_addr: rdata_next = detect_active ?                    // [R6] [R13]
                                      {stable_level, 6'h00} : 8'h00;
        irq_mask_addr:   rdata_next = irq_mask_reg;
        plug_detect_config_addr: rdata_next = config_reg;
        default:         rdata_next = unmapped_read_value;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// ==== plug_detect_irq_sva.sv ====
// assertion checker for the plug-detect block ports
`timescale 1ns/100ps
module plug_detect_irq_sva
  import plug_detect_pkg::*;
#(
  parameter int tick_div = tick_cycles
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // register port
  input wire logic       reg_access,
  input wire logic       reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // device state
  input wire logic       power_down_n,
  input wire logic       mic_bias_on,
  input wire logic       aux_measure_sel,
  input wire logic [1:0] left_preamp_gain,
  input wire logic [1:0] right_preamp_gain,
  input wire logic [1:0] sense_pin_cmp,
  // outputs
  input wire logic       pullup_strong_en,
  input wire logic       pullup_weak_en,
  input wire logic       comparator_en,
  input wire logic       aux_path_en,
  input wire logic       irq_n_out,
  input wire logic       irq_n_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // -----------------------------------------------------------------
  // helper state
  // -----------------------------------------------------------------
  // shortest select less one tick, since the first tick may come early
  localparam int min_quiet = 24 * tick_div;
  logic [2:0]  up_reg, up_next;
  logic [31:0] quiet_reg, quiet_next;
  logic [1:0]  cmp_reg;
  logic        mask_reg, mask_next;
  logic        up_ok;
  assign up_ok = (up_reg == 3'h7);
  always_comb begin
    up_next = up_ok ? up_reg : up_reg + 3'h1;
    quiet_next = (sense_pin_cmp != cmp_reg) ? 32'h0 : quiet_reg + 32'h1;
    mask_next = mask_reg;
    if (reg_access && reg_write && reg_addr == irq_mask_addr) begin
      mask_next = reg_wdata[plug_change_bit];
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      up_reg <= 3'h0;
      quiet_reg <= 32'h0;
      cmp_reg <= level_high;
      mask_reg <= 1'b0;
    end else begin
      up_reg <= up_next;
      quiet_reg <= quiet_next;
      cmp_reg <= sense_pin_cmp;
      mask_reg <= mask_next;
    end
  end
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  sequence status_read;
    reg_access && !reg_write && reg_addr == irq_flags_addr;
  endsequence
  sequence level_read;
    reg_access && !reg_write && reg_addr == plug_level_addr;
  endsequence
  AST_IRQ_DRAIN_ONLY: assert property (irq_n_out == 1'b0)
    else $error("interrupt pin driven high");
  AST_IRQ_HELD: assert property ($fell(irq_n_oe) |->
    $past(reg_access && !reg_write && reg_addr == irq_flags_addr))
    else $error("interrupt released without status read");
  // mask as it stood at the edge that raised the line
  AST_IRQ_MASKED: assert property ($rose(irq_n_oe) |-> $past(mask_reg))
    else $error("interrupt raised while masked");
  AST_SETTLE_MIN: assert property ($rose(irq_n_oe) |-> quiet_reg >= min_quiet)
    else $error("change reported before settle time");
  AST_SLEEP_NO_CMP: assert property ((up_ok && !power_down_n)[*2] |-> !comparator_en)
    else $error("comparator on in sleep");
  AST_AUX_PATH: assert property ((up_ok && aux_measure_sel)[*2] |-> aux_path_en && !comparator_en)
    else $error("pin not handed to aux path");
  AST_WEAK_WHEN: assert property (pullup_weak_en |-> !$past(power_down_n) || !$past(mic_bias_on))
    else $error("weak pull-up outside sleep or bias off");
  AST_GAIN_STRONG: assert property (pullup_weak_en |->
    $past(left_preamp_gain) == 2'h0 && $past(right_preamp_gain) == 2'h0)
    else $error("weak pull-up with preamp gain set");
  AST_ONE_PULL: assert property (!(pullup_strong_en && pullup_weak_en))
    else $error("both pull-ups on");
  AST_LEVEL_FIELD: assert property (level_read |=>
    reg_rdata[5:0] == 6'h00 && reg_rdata[7:6] != level_invalid)
    else $error("bad level register value");
  cover property (status_read ##1 !irq_n_oe);
endmodule

bind plug_detect_irq plug_detect_irq_sva #(.tick_div(tick_div)) u_sva (
  .core_clk(core_clk), .nrst(nrst), .reg_access(reg_access), .reg_write(reg_write),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .power_down_n(power_down_n), .mic_bias_on(mic_bias_on), .aux_measure_sel(aux_measure_sel),
  .left_preamp_gain(left_preamp_gain), .right_preamp_gain(right_preamp_gain),
  .sense_pin_cmp(sense_pin_cmp), .pullup_strong_en(pullup_strong_en),
  .pullup_weak_en(pullup_weak_en), .comparator_en(comparator_en), .aux_path_en(aux_path_en),
  .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// ==== jack_model.sv ====
// headset jack and interrupt line pull-up as seen at the pins
`timescale 1ns/100ps
module jack_model
  import plug_detect_pkg::*;
(
  // plug request: 0 none, 1 headset, 2 headphone
  input  wire logic [1:0] plug_kind,
  input  wire logic       bad_contact,
  // pins
  input  wire logic       irq_n_out,
  input  wire logic       irq_n_oe,
  output logic [1:0]      sense_pin_cmp,
  output logic            irq_line
);
  always_comb begin
    case (plug_kind)
      2'h1:    sense_pin_cmp = level_mid;
      2'h2:    sense_pin_cmp = level_low;
      default: sense_pin_cmp = level_high;
    endcase
    // a dirty contact can give the code no real level has
    if (bad_contact) begin
      sense_pin_cmp = level_invalid;
    end
  end
  // board pull-up holds the line high when nobody sinks it
  assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
endmodule

// ==== tb_plug_detect_irq.sv ====
// self-checking bench for the plug-detect block
`timescale 1ns/100ps
module tb_plug_detect_irq
  import plug_detect_pkg::*;
;
  localparam int tdiv = 10;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       reg_access = 1'b0;
  logic       reg_write = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       power_down_n = 1'b1;
  logic       mic_bias_on = 1'b1;
  logic       aux_measure_sel = 1'b0;
  logic [1:0] left_preamp_gain = 2'h0;
  logic [1:0] right_preamp_gain = 2'h0;
  logic [1:0] plug_kind = 2'h0;
  logic       bad_contact = 1'b0;
  logic [7:0] reg_rdata, rd;
  logic [1:0] sense_pin_cmp;
  logic       pullup_strong_en, pullup_weak_en, comparator_en, aux_path_en;
  logic       irq_n_out, irq_n_oe, irq_line;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         wait_n;
  int         ms_tab[4] = '{settle_ms_0, settle_ms_1, settle_ms_2, settle_ms_3};
  logic [1:0] kind_tab[4] = '{2'h1, 2'h0, 2'h2, 2'h0};
  logic [1:0] lvl_tab[4] = '{level_mid, level_high, level_low, level_high};

  plug_detect_irq #(.tick_div(tdiv)) DUT (
    .core_clk(core_clk), .nrst(nrst), .reg_access(reg_access), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .power_down_n(power_down_n), .mic_bias_on(mic_bias_on), .aux_measure_sel(aux_measure_sel),
    .left_preamp_gain(left_preamp_gain), .right_preamp_gain(right_preamp_gain),
    .sense_pin_cmp(sense_pin_cmp), .pullup_strong_en(pullup_strong_en),
    .pullup_weak_en(pullup_weak_en), .comparator_en(comparator_en), .aux_path_en(aux_path_en),
    .irq_n_in(irq_line), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  jack_model plug (
    .plug_kind(plug_kind), .bad_contact(bad_contact), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .sense_pin_cmp(sense_pin_cmp), .irq_line(irq_line));

  always #50 core_clk = ~core_clk;

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_access <= 1'b1;
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_access <= 1'b0;
  endtask
  // read data is sampled just after the edge that takes the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string what);
    @(posedge core_clk);
    reg_access <= 1'b1;
    reg_write <= 1'b0;
    reg_addr <= a;
    @(posedge core_clk);
    reg_access <= 1'b0;
    #1;
    rd = reg_rdata;
    check(rd & m, e, what);
  endtask
  task automatic wait_irq(input int lim);
    wait_n = 0;
    while (irq_line !== 1'b0 && wait_n < lim) begin
      @(posedge core_clk);
      wait_n++;
    end
  endtask
  task automatic settle(input int sel, input logic [1:0] kind, input logic [1:0] lvl,
                        input int pre);
    int ms;
    ms = ms_tab[sel];
    wr(plug_detect_config_addr, 8'h80 | 8'(sel));
    repeat (2) @(posedge core_clk);
    check({6'h0, pullup_strong_en, comparator_en}, 8'h03, "strong pull");
    if (pre > 0) begin
      plug_kind <= 2'h1;
      repeat (pre) @(posedge core_clk);
    end
    plug_kind <= kind;
    wait_irq(2 * ms * tdiv + 50);
    check(8'(wait_n >= (ms - 1) * tdiv && wait_n <= (ms + 1) * tdiv + 10), 8'h01, "settle");
    rd_chk(plug_level_addr, 8'hff, {lvl, 6'h00}, "level");
    check({7'h0, irq_line}, 8'h00, "irq held");
    rd_chk(irq_flags_addr, 8'h02, 8'h02, "change flag");
    check({7'h0, irq_line}, 8'h01, "irq released");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    #2_000_000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd_chk(irq_mask_addr, 8'hff, irq_mask_reset, "mask reset");
    rd_chk(plug_detect_config_addr, 8'hff, plug_detect_config_reset, "config reset");
    rd_chk(irq_flags_addr, 8'h02, 8'h00, "no change");
    rd_chk(plug_level_addr, 8'hff, 8'h00, "level off");
    wr(irq_mask_addr, 8'hff);
    rd_chk(irq_mask_addr, 8'hff, irq_mask_writable, "mask bits");
    wr(plug_detect_config_addr, 8'hff);
    rd_chk(plug_detect_config_addr, 8'hff, 8'ha3, "config bits");
    wr(plug_level_addr, 8'h40);
    rd_chk(plug_level_addr, 8'hff, 8'hc0, "level ro");
    rd_chk(8'h10, 8'hff, unmapped_read_value, "unmapped");
    rd_chk(irq_flags_addr, 8'h00, 8'h00, "clear");
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      settle(i, kind_tab[i], lvl_tab[i], 0);
    end
    settle(0, 2'h2, level_low, 150);
    $display("settle done");
    wr(irq_mask_addr, 8'h00);
    plug_kind <= 2'h1;
    repeat (300) @(posedge core_clk);
    check({7'h0, irq_line}, 8'h01, "masked irq");
    rd_chk(irq_flags_addr, 8'h02, 8'h02, "flag masked");
    wr(irq_mask_addr, 8'h02);
    bad_contact <= 1'b1;
    repeat (300) @(posedge core_clk);
    rd_chk(plug_level_addr, 8'hff, 8'h00, "invalid code");
    bad_contact <= 1'b0;
    repeat (300) @(posedge core_clk);
    rd_chk(irq_flags_addr, 8'h00, 8'h00, "clear");
    $display("mask done");
    // host sets the low-power pull-up once the headset is known
    wr(plug_detect_config_addr, 8'ha0);
    power_down_n <= 1'b0;
    repeat (300) @(posedge core_clk);
    check({5'h0, pullup_strong_en, pullup_weak_en, comparator_en}, 8'h02, "sleep weak");
    rd_chk(plug_level_addr, 8'hff, 8'h00, "weak level");
    left_preamp_gain <= 2'h1;
    repeat (3) @(posedge core_clk);
    check({6'h0, pullup_strong_en, pullup_weak_en}, 8'h02, "gain strong");
    left_preamp_gain <= 2'h0;
    power_down_n <= 1'b1;
    mic_bias_on <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({5'h0, pullup_strong_en, pullup_weak_en, comparator_en}, 8'h03, "bias off weak");
    mic_bias_on <= 1'b1;
    wr(plug_detect_config_addr, 8'h80);
    rd_chk(irq_flags_addr, 8'h00, 8'h00, "clear");
    $display("pull-up done");
    aux_measure_sel <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({6'h0, aux_path_en, comparator_en}, 8'h02, "aux path");
    rd_chk(plug_level_addr, 8'hff, 8'h00, "aux level");
    aux_measure_sel <= 1'b0;
    $display("aux done");
    report_and_stop();
  end
endmodule
